// >>> hw/pdi_top.sv
// parallel dma byte input port with register access
// =====================================================
// Overview of operation
// - strap at reset picks serial or dma
// - startup bit 4 set selects dma input
// - upper eight lines form byte, msb high
// - request rise, ready-to-read low acknowledges
// - byte captured 120 to 480 ns after edge
// - end-of-block low, host drops request, restarts
// - fifteen bytes per block, sixteenth refused
// - late sixteenth edge starts block silently
// - ready-to-read rise forms sixteenth edge
// - strap no longer picks clock; 14.725 mhz
// - no status on low lines in dma
// - request pin is dma request or r/w
`timescale 1ns/1ps
`include "pdi_consts.svh"
module pdi_top
  import pdi_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // axi4-lite slave
  input wire logic [31:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [31:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // device pins
  input wire logic input_select_strap,
  input wire logic dma_request,
  input wire logic [7:0] parallel_byte_lines,
  output logic ready_to_read_n,
  output logic end_of_block_n,
  output logic status_lines_oe,
  // decoder side
  output pdi_byte_s byte_out,
  output logic dma_mode
);
  // =====================================================
  // pin synchronisers
  logic req_s;
  logic strap_s;
  logic req_prev_q;
  logic dma_mode_q; // input path: high selects the parallel byte port
  pdi_sync3 u_sync_req (
    .clk(clk),
    .rst(rst),
    .pin(dma_request),
    .level(req_s)
  );
  pdi_sync3 u_sync_strap (
    .clk(clk),
    .rst(rst),
    .pin(input_select_strap),
    .level(strap_s)
  );
  // the request pin means read/write outside dma mode
  wire req_rise = req_s && !req_prev_q && dma_mode_q;
  // =====================================================
  // registers
  logic [`PDI_REG_W-1:0] port_cfg_q;
  logic [`PDI_REG_W-1:0] startup_q;
  logic strap_done_q; // strap caught once after release
  logic [2:0] strap_wait_q; // edges since release, until the strap settles
  logic wr_en;
  logic [9:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [9:0] rd_addr;
  wire [31:0] wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  wire wr_port = wr_en && (wr_addr == `PDI_ADDR_PORT_CFG);
  wire wr_start = wr_en && (wr_addr == `PDI_ADDR_STARTUP_CFG);
  wire [31:0] start_new = ({12'h000, startup_q} & ~wmask) | (wr_data & wmask);
  wire [31:0] port_new = ({12'h000, port_cfg_q} & ~wmask) | (wr_data & wmask);
  // address decode
  logic wr_ok;
  logic rd_ok;
  logic [31:0] rd_data;
  assign wr_ok = (wr_addr == `PDI_ADDR_PORT_CFG) || (wr_addr == `PDI_ADDR_STARTUP_CFG);
  assign rd_ok = (rd_addr == `PDI_ADDR_PORT_CFG) || (rd_addr == `PDI_ADDR_STARTUP_CFG)
    || (rd_addr == `PDI_ADDR_STATUS) || (rd_addr == `PDI_ADDR_DATA);
  logic [3:0] count_q;
  logic [7:0] last_byte_q;
  pdi_state_e state_q;
  always_comb begin
    if (rd_addr == `PDI_ADDR_PORT_CFG) begin
      rd_data = {12'h000, port_cfg_q};
    end else if (rd_addr == `PDI_ADDR_STARTUP_CFG) begin
      rd_data = {12'h000, startup_q};
    end else if (rd_addr == `PDI_ADDR_STATUS) begin
      // block state: mode, eob, rtr, byte count
      rd_data = {24'h000000, dma_mode_q, end_of_block_n, ready_to_read_n, 1'b0, count_q};
    end else if (rd_addr == `PDI_ADDR_DATA) begin
      rd_data = {24'h000000, last_byte_q};
    end else begin
      rd_data = 32'h00000000;
    end
  end
  pdi_axil u_axil (
    .clk(clk),
    .rst(rst),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );
  // register file and mode select; the clock is fixed, the strap
  // only chooses the input path
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_cfg_q <= `PDI_PORT_CFG_RST;
      startup_q <= `PDI_STARTUP_CFG_RST;
      strap_done_q <= 1'b0;
      strap_wait_q <= 3'd0;
      dma_mode_q <= 1'b0;
    end else begin
      // the filtered strap is trusted only once the synchroniser has settled;
      // at the first edge it would always show the reset level
      if (strap_wait_q != `PDI_STRAP_SETTLE) begin
        strap_wait_q <= strap_wait_q + 3'd1;
      end else if (!strap_done_q) begin
        strap_done_q <= 1'b1;
        dma_mode_q <= strap_s;
        startup_q[`PDI_BIT_DMA_SEL] <= strap_s;
      end
      if (wr_start) begin
        startup_q <= start_new[`PDI_REG_W-1:0];
        // set bit enters dma mode; clearing alone keeps it
        if (start_new[`PDI_BIT_DMA_SEL]) begin
          dma_mode_q <= 1'b1;
        end
      end
      if (wr_port) begin
        port_cfg_q <= port_new[`PDI_REG_W-1:0];
        // serial return needs bit 4 already clear
        if (port_new[`PDI_REG_W-1:0] == `PDI_PORT_CFG_SERIAL && !startup_q[`PDI_BIT_DMA_SEL]) begin
          dma_mode_q <= 1'b0;
        end
      end
    end
  end
  // =====================================================
  // handshake engine
  logic [9:0] tmr_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= PDI_IDLE;
      tmr_q <= 10'h000;
      count_q <= 4'h0;
      last_byte_q <= 8'h00;
      req_prev_q <= 1'b0;
      ready_to_read_n <= 1'b1;
      end_of_block_n <= 1'b1;
      byte_out <= '0;
      status_lines_oe <= 1'b0;
      dma_mode <= 1'b0;
    end else begin
      req_prev_q <= req_s;
      byte_out.valid <= 1'b0;
      dma_mode <= dma_mode_q;
      status_lines_oe <= !dma_mode_q;
      if (tmr_q != 10'h000) begin
        tmr_q <= tmr_q - 10'h001;
      end
      case (state_q)
        PDI_IDLE: begin
          // first request edge of a block
          if (req_rise) begin
            state_q <= PDI_WAIT_CAP;
            tmr_q <= 10'(`PDI_CAPTURE_CYC);
          end
        end
        PDI_WAIT_CAP: begin
          // capture 120 ns after the edge
          if (tmr_q == 10'h001) begin
            last_byte_q <= parallel_byte_lines;
            byte_out.data <= parallel_byte_lines;
            byte_out.valid <= 1'b1;
            count_q <= count_q + 4'h1;
            ready_to_read_n <= 1'b0;
            tmr_q <= 10'(`PDI_RTR_CYC);
            state_q <= PDI_ACK;
          end
        end
        PDI_ACK: begin
          if (tmr_q == 10'h001) begin
            ready_to_read_n <= 1'b1;
            tmr_q <= 10'(`PDI_LATE_CYC);
            state_q <= PDI_WAIT_REQ;
          end
        end
        PDI_WAIT_REQ: begin
          if (req_rise && count_q == `PDI_BLOCK_BYTES) begin
            // sixteenth edge in time: refused, block ends
            end_of_block_n <= 1'b0;
            count_q <= 4'h0;
            tmr_q <= 10'(`PDI_EOD_CYC);
            state_q <= PDI_EOB;
          end else if (req_rise) begin
            state_q <= PDI_WAIT_CAP;
            tmr_q <= 10'(`PDI_CAPTURE_CYC);
          end else if (count_q == `PDI_BLOCK_BYTES && tmr_q == 10'h001) begin
            // late edge: new block silently, no eob pulse
            count_q <= 4'h0;
            state_q <= PDI_IDLE;
          end
        end
        PDI_EOB: begin
          // edges ignored while eob is low
          if (tmr_q == 10'h000 && !req_s) begin
            end_of_block_n <= 1'b1;
            state_q <= PDI_IDLE;
          end
        end
        default: begin
          state_q <= PDI_IDLE;
        end
      endcase
    end
  end
  // =====================================================
  // checks
  property p_cap_ack;
    @(posedge clk) disable iff (rst)
    $fell(ready_to_read_n) |-> byte_out.valid;
  endproperty
  a_cap_ack: assert property (p_cap_ack) else $error("ack without capture");
  property p_cap_time;
    @(posedge clk) disable iff (rst)
    (state_q == PDI_IDLE && req_rise) |-> ##25 byte_out.valid;
  endproperty
  a_cap_time: assert property (p_cap_time) else $error("capture time wrong");
  property p_count;
    @(posedge clk) disable iff (rst)
    byte_out.valid |-> $past(count_q) != `PDI_BLOCK_BYTES;
  endproperty
  a_count: assert property (p_count) else $error("byte taken past block end");
  property p_eob_idle;
    @(posedge clk) disable iff (rst)
    !end_of_block_n |-> ready_to_read_n && !byte_out.valid;
  endproperty
  a_eob_idle: assert property (p_eob_idle) else $error("activity during eob");
  property p_eob_cnt;
    @(posedge clk) disable iff (rst)
    $fell(end_of_block_n) |-> $past(count_q) == `PDI_BLOCK_BYTES;
  endproperty
  a_eob_cnt: assert property (p_eob_cnt) else $error("eob early");
  property p_status_oe;
    @(posedge clk) disable iff (rst)
    dma_mode |-> !status_lines_oe;
  endproperty
  a_status_oe: assert property (p_status_oe) else $error("status in dma mode");
endmodule

// >>> common/pdi_consts.svh
// constants for the parallel dma byte input block
`ifndef PDI_CONSTS_SVH
`define PDI_CONSTS_SVH
// =====================================================
// register map (printed offsets are not word multiples: index * 4)
`define PDI_IDX_PORT_CFG 8'h4b
`define PDI_IDX_STARTUP_CFG 8'he6
`define PDI_IDX_STATUS 8'hf0
`define PDI_ADDR_PORT_CFG 10'h12c
`define PDI_ADDR_STARTUP_CFG 10'h398
`define PDI_ADDR_STATUS 10'h3c0
`define PDI_ADDR_DATA 10'h3c4
`define PDI_REG_W 20
`define PDI_PORT_CFG_RST 20'h00000
`define PDI_STARTUP_CFG_RST 20'h00000
`define PDI_PORT_CFG_SERIAL 20'h00082
`define PDI_BIT_DMA_SEL 4
// =====================================================
// timing at 200 MHz (5 ns period)
`define PDI_CLK_PS 5000
`define PDI_CAPTURE_MIN_NS 120
`define PDI_CAPTURE_MAX_NS 480
`define PDI_CAPTURE_CYC ((`PDI_CAPTURE_MIN_NS * 1000 + `PDI_CLK_PS - 1) / `PDI_CLK_PS)
`define PDI_RTR_NS 200
`define PDI_RTR_CYC ((`PDI_RTR_NS * 1000 + `PDI_CLK_PS - 1) / `PDI_CLK_PS)
`define PDI_LATE_NS 3500
`define PDI_LATE_CYC ((`PDI_LATE_NS * 1000) / `PDI_CLK_PS)
`define PDI_EOD_NS 500
`define PDI_EOD_CYC ((`PDI_EOD_NS * 1000 + `PDI_CLK_PS - 1) / `PDI_CLK_PS)
`define PDI_BLOCK_BYTES 4'd15
// edges after reset before the filtered strap level is trusted
`define PDI_STRAP_SETTLE 3'd5
`define PDI_INPUT_CLK_KHZ 14725
`endif

// >>> common/pdi_pkg.sv
// types for the parallel dma byte input block
package pdi_pkg;
  // handshake states of the byte port
  typedef enum logic [2:0] {
    PDI_IDLE,
    PDI_WAIT_CAP,
    PDI_ACK,
    PDI_WAIT_REQ,
    PDI_EOB
  } pdi_state_e;
  // captured byte towards the decoder
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } pdi_byte_s;
endpackage

// >>> hw/pdi_sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pdi_sync3 (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pin and filtered level
  input wire logic pin,
  output logic level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  // first stage is read only by the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // a change counts once stages two and three agree
      if (s2_q == s3_q) begin
        level <= s3_q;
      end
    end
  end
endmodule

// >>> hw/pdi_axil.sv
// axi4-lite slave for the block registers
`timescale 1ns/1ps
module pdi_axil
  import pdi_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // write channels
  input wire logic [31:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // read channels
  input wire logic [31:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // register side
  output logic wr_en,
  output logic [9:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  output logic [9:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);
  logic aw_have_q;
  logic w_have_q;
  logic [9:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  // both halves held, response slot free
  wire do_write = aw_have_q && w_have_q && !s_bvalid;
  assign wr_en = do_write;
  assign wr_addr = awaddr_q;
  assign wr_data = wdata_q;
  assign wr_strb = wstrb_q;
  assign s_awready = !aw_have_q;
  assign s_wready = !w_have_q;
  assign s_arready = !s_rvalid;
  assign rd_addr = s_araddr[9:0];
  // write path: address and data taken in either order
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 10'h000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_bvalid <= 1'b0;
      s_bresp <= 2'b00;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_awaddr[9:0];
      end
      if (s_wvalid && s_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_wdata;
        wstrb_q <= s_wstrb;
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_bvalid <= 1'b1;
        // unmapped address answers slverr
        s_bresp <= wr_ok ? 2'b00 : 2'b10;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end
  // read path: one cycle from address to data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_rvalid <= 1'b0;
      s_rdata <= 32'h00000000;
      s_rresp <= 2'b00;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rdata <= rd_ok ? rd_data : 32'h00000000;
      s_rresp <= rd_ok ? 2'b00 : 2'b10;
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
    end
  end
endmodule

// >>> sim/pdi_ctrl_model.sv
// controller model that writes bitstream bytes into the port
`timescale 1ns/1ps
module pdi_ctrl_model (
  // clock
  input wire logic clk,
  // port pins
  input wire logic ready_to_read_n,
  input wire logic end_of_block_n,
  output logic dma_request,
  output logic [7:0] parallel_byte_lines
);
  // =====================================================
  // idle pins: request low, lines at a junk pattern
  initial begin
    dma_request = 1'b0;
    parallel_byte_lines = 8'h5a;
  end
  // the block has no serial input: the serial clock counts as stopped at 0
  // one byte; gap delays the request edge so the late-edge case can be forced
  task automatic send(input logic [7:0] b, input int gap, output logic ack, output logic eob,
    output logic to);
    int n;
    to = 1'b0;
    repeat (gap) @(posedge clk);
    // one edge first, so the released lines are not driven twice in a step
    @(posedge clk);
    parallel_byte_lines <= b;
    // data settles 160 ns ahead, since capture may come 120 ns after the edge
    repeat (32) @(posedge clk);
    dma_request <= 1'b1;
    n = 0;
    while (ready_to_read_n && end_of_block_n && n < 300) begin
      @(posedge clk);
      n++;
    end
    ack = !ready_to_read_n;
    eob = !end_of_block_n;
    to = (n >= 300);
    n = 0;
    // hold byte and request until ready-to-read rises again
    while (!ready_to_read_n && n < 100) begin
      @(posedge clk);
      n++;
    end
    to = to || (n >= 100);
    @(posedge clk);
    dma_request <= 1'b0;
    parallel_byte_lines <= ~b;
    n = 0;
    // no new block before end-of-block is high again
    while (!end_of_block_n && n < 400) begin
      @(posedge clk);
      n++;
    end
    to = to || (n >= 400);
  endtask
  // byte set up ahead of a request that the external mux makes
  task automatic put(input logic [7:0] b);
    @(posedge clk);
    parallel_byte_lines <= b;
    repeat (32) @(posedge clk);
  endtask
endmodule

// >>> sim/tb_top.sv
// self-checking bench for the parallel dma byte input port
`timescale 1ns/1ps
`include "pdi_consts.svh"
module tb_top
  import pdi_pkg::*;
;
  logic clk, rst, strap, req, rtr_n, eob_n, oe, dmode;
  logic [31:0] awaddr, wdata, araddr, rdata, rd;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, ack, eob;
  logic [1:0] bresp, rresp, rr;
  logic [7:0] lines;
  logic controller_request, mux_select;
  pdi_byte_s bo;
  int n_mismatch, total_checks, i;
  logic [7:0] got[$];
  logic [7:0] exp_q[$];

  pdi_top pdi_top_i (.clk(clk), .rst(rst), .s_awaddr(awaddr), .s_awvalid(awvalid),
    .s_awready(awready), .s_wdata(wdata), .s_wstrb(4'hf), .s_wvalid(wvalid),
    .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
    .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
    .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready), .input_select_strap(strap),
    .dma_request(req), .parallel_byte_lines(lines), .ready_to_read_n(rtr_n),
    .end_of_block_n(eob_n), .status_lines_oe(oe), .byte_out(bo), .dma_mode(dmode));
  pdi_ctrl_model pdi_ctrl_model_i (.clk(clk), .ready_to_read_n(rtr_n),
    .end_of_block_n(eob_n), .dma_request(controller_request), .parallel_byte_lines(lines));
  // external two-input mux: controller request, or ready-to-read looped back
  assign req = mux_select ? rtr_n : controller_request;

  // =====================================================
  // 200 mhz clock and capture monitor
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (bo.valid === 1'b1) got.push_back(bo.data);
  end

  // =====================================================
  // compare, report and bus tasks
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic cmp_val(input logic [31:0] g, input logic [31:0] e, input string m);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic cmp_bit(input logic g, input logic e, input string m);
    cmp_val({31'h0, g}, {31'h0, e}, m);
  endtask
  task automatic tmo(input logic hit);
    if (hit) begin
      n_mismatch++;
      $display("mismatch %0t bus timeout", $time);
      final_report();
    end
  endtask
  // write: address and data offered together, each dropped once taken
  task automatic axw(input logic [9:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    awaddr <= {22'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 100);
    bready <= 1'b0;
    tmo(n >= 100);
    cmp_val({30'h0, bresp}, 32'h0, "write response");
    repeat (5) @(posedge clk); // mode flag lags the register by a cycle
  endtask
  task automatic axr(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    araddr <= {22'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 100);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    tmo(n >= 100);
  endtask
  // one byte through the model, with the expected ack and end-of-block
  task automatic byte_chk(input int k, input int gap, input logic ea, input logic ee);
    logic [7:0] b;
    logic to;
    b = 8'(k * 29 + 128);
    pdi_ctrl_model_i.send(b, gap, ack, eob, to);
    tmo(to);
    cmp_bit(ack, ea, "byte ack");
    cmp_bit(eob, ee, "end of block");
    if (ea) exp_q.push_back(b);
  endtask
  // 15th and 16th request edges made by the mux from ready-to-read
  task automatic mux_blk(input logic [7:0] b);
    int n;
    pdi_ctrl_model_i.put(b);
    exp_q.push_back(b);
    mux_select <= 1'b1;
    n = 0;
    while (eob_n && n < 400) begin
      @(posedge clk);
      n++;
    end
    tmo(n >= 400);
    cmp_bit(eob_n, 1'b0, "mux block end");
    mux_select <= 1'b0;
    n = 0;
    while (!eob_n && n < 400) begin
      @(posedge clk);
      n++;
    end
    tmo(n >= 400);
    cmp_bit(eob_n, 1'b1, "end of block released");
  endtask

  // =====================================================
  // main sequence
  initial begin
    rst = 1'b1;
    strap = 1'b0;
    awaddr = 32'h0;
    wdata = 32'h0;
    araddr = 32'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    mux_select = 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    cmp_bit(dmode, 1'b0, "serial after reset");
    cmp_bit(oe, 1'b1, "status lines in serial");
    axr(`PDI_ADDR_STARTUP_CFG, rd, rr);
    cmp_val(rd, 32'h0, "startup reset");
    axr(`PDI_ADDR_PORT_CFG, rd, rr);
    cmp_val(rd, 32'h0, "port cfg reset");
    axr(10'h200, rd, rr);
    cmp_val({rd[29:0], rr}, 32'h2, "unmapped read");
    axw(`PDI_ADDR_STARTUP_CFG, 32'h1 << `PDI_BIT_DMA_SEL);
    cmp_bit(dmode, 1'b1, "dma after bit set");
    cmp_bit(oe, 1'b0, "no status in dma");
    for (i = 0; i < 15; i++) byte_chk(i, 0, 1'b1, 1'b0);
    byte_chk(15, 0, 1'b0, 1'b1);
    for (i = 15; i < 30; i++) byte_chk(i, 0, 1'b1, 1'b0);
    byte_chk(30, 700, 1'b1, 1'b0);
    for (i = 31; i < 45; i++) byte_chk(i, 0, 1'b1, 1'b0);
    byte_chk(45, 0, 1'b0, 1'b1);
    for (i = 46; i < 60; i++) byte_chk(i, 0, 1'b1, 1'b0);
    mux_blk(8'(60 * 29 + 128));
    cmp_val(32'(got.size()), 32'(exp_q.size()), "capture count");
    for (i = 0; i < exp_q.size() && i < got.size(); i++) begin
      cmp_val({24'h0, got[i]}, {24'h0, exp_q[i]}, "captured byte");
    end
    axr(`PDI_ADDR_DATA, rd, rr);
    cmp_val(rd, {24'h0, 8'(60 * 29 + 128)}, "last byte register");
    axr(`PDI_ADDR_STATUS, rd, rr);
    cmp_val(rd, 32'he0, "block status");
    // mode changed here only to test switching; a real host keeps it
    axw(`PDI_ADDR_PORT_CFG, {12'h0, `PDI_PORT_CFG_SERIAL});
    cmp_bit(dmode, 1'b1, "exit refused with bit set");
    axw(`PDI_ADDR_STARTUP_CFG, 32'h0);
    axw(`PDI_ADDR_PORT_CFG, {12'h0, `PDI_PORT_CFG_SERIAL});
    cmp_bit(dmode, 1'b0, "serial after exit");
    cmp_bit(oe, 1'b1, "status lines back");
    strap <= 1'b1;
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    cmp_bit(dmode, 1'b1, "strap selects dma");
    axr(`PDI_ADDR_STARTUP_CFG, rd, rr);
    cmp_val(rd, 32'h10, "strap sets mode bit");
    final_report();
  end
endmodule
